// File: pkg/pci_bridge_write_pkg.sv
// Constants, register map and state encodings of the bridge write-forwarding path.
// Assumes one 10 MHz system clock and a synchronous, active-high reset.
package pci_bridge_write_pkg;

  // Bus commands
  localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  localparam logic [3:0] CMD_MWI       = 4'hf;
  localparam logic [1:0] CFG_TYPE1     = 2'h1;

  // Register map
  localparam logic [7:0]  REG_WINV_CTRL     = 8'h74;
  localparam logic [7:0]  REG_RETRY_DISCARD = 8'h78;
  localparam logic [31:0] WINV_CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] DISCARD_RESET     = 32'h0000_8000;
  localparam int          MWI_FIELD_LO      = 7;
  localparam int          MWI_FIELD_HI      = 8;
  localparam logic [1:0]  MWI_LINE_DISC     = 2'h3;
  localparam logic [1:0]  MWI_AS_WRITE      = 2'h0;

  // Address ranges and boundaries
  localparam logic [31:0] VGA_LOW        = 32'h000a_0000;
  localparam logic [31:0] VGA_HIGH       = 32'h000b_ffff;
  localparam logic [9:0]  PAGE_LAST_WORD = 10'h3ff;
  localparam logic [7:0]  CLS_MAX        = 8'h10;
  localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;

  // Posted queue layout
  localparam int          FIFO_WIDTH   = 38;
  localparam int          FIFO_DEPTH   = 32;
  localparam int          FIFO_AW      = 5;
  localparam int          FW_IS_ADDR   = 37;
  localparam int          FW_EOT       = 36;
  localparam logic [5:0]  LEVEL_ROOM   = 6'h1e;
  localparam logic [5:0]  LEVEL_NEAR   = 6'h1f;
  localparam logic [5:0]  LEVEL_ONE    = 6'h01;

  // Synchroniser reset values (control and byte-enable lines idle high, AD zero)
  localparam logic [37:0] P_SYNC_RESET = {2'h3, 4'hf, 32'h0};
  localparam logic [5:0]  S_SYNC_RESET = 6'h3f;

  localparam logic [32:0] RETRY_LIMIT_DEFAULT = 33'h001000000;

  typedef enum logic [5:0] {
    T_IDLE = 6'h01, T_DECODE = 6'h02, T_CLAIM = 6'h04,
    T_DATA = 6'h08, T_DLY = 6'h10, T_WAIT = 6'h20
  } tgt_state_e;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01, M_REQ = 5'h02, M_ADDR = 5'h04, M_DATA = 5'h08, M_TURN = 5'h10
  } mst_state_e;

  typedef enum logic [2:0] {
    D_EMPTY = 3'h1, D_PEND = 3'h2, D_DONE = 3'h4
  } dly_state_e;

endpackage

// File: rtl/pci_bridge_write_forwarding.sv
// Write-forwarding path of a two-port bus bridge, initiator bus to target bus.
// Assumes bus pins arrive asynchronously; configuration inputs share clk_sys.
//
// Overview of operation
// - Claim only by positive decode at medium timing, never subtractively.
// - A data phase completes when IRDY with TRDY or STOP is asserted.
// - Data moves only when IRDY and TRDY are both asserted.
// - Last phase: FRAME off with IRDY and TRDY, or IRDY with STOP.
// - Post plain and invalidate memory writes; delay VGA, I/O, type 1 config.
// - Posted write: DEVSEL medium, TRDY next cycle, needs room for address plus one word.
// - Posted data taken every clock without target wait states.
// - Disconnect at cache line, 4KB boundary or when the posted buffer fills; cache line only for invalidate writes with field 11.
// - Request the target bus once posted data is at the queue head.
// - With grant and idle bus drive address, then one word per clock.
// - Queue empties mid-flow: mark last phase, restart when data returns.
// - End on delivery, disconnect, retry, latency expiry; drop rest on abort.
// - Field 11 at 74h: disconnect invalidate writes at cache line boundaries.
// - Field 00 at 74h: forward invalidate writes as plain memory writes.
// - Every delayed write carries exactly one word.
// - First delayed write: claim, retry, capture command, address, data, enables.
// - Enqueue a delayed write only into a free, non-duplicate entry.
// - Issue the head delayed write after posted data, repeat on retry.
// - Retry limit exceeded: flag system error when error reporting enabled.
// - Matching repeat with completion at head: TRDY, plus STOP for more words.
// - Repeat before delivery: keep retrying, no second entry.
// - Discard timer from 78h drops an unclaimed completion, may flag error.

////////////////////////////////////////////////////////////////////////////////
module post_write_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;

  assign level    = wrPtr_q - rdPtr_q;
  assign inReady  = level != (AW+1)'(DEPTH);
  assign outValid = level != '0;
  assign outData  = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (inValid && inReady) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pci_bridge_write_forwarding
  import pci_bridge_write_pkg::*;
#(
  parameter logic [32:0] RETRY_LIMIT = RETRY_LIMIT_DEFAULT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] pAdIn,
  input  wire logic [3:0]  pCbeInN,
  input  wire logic        pFrameInN,
  input  wire logic        pIrdyInN,
  output logic             pDevselOutN,
  output logic             pDevselOeN,
  output logic             pTrdyOutN,
  output logic             pTrdyOeN,
  output logic             pStopOutN,
  output logic             pStopOeN,
  output logic             primary_system_error_out_n,
  output logic             pSerrOeN,
  output logic             sReqOutN,
  input  wire logic        sGntInN,
  output logic [31:0]      sAdOut,
  output logic             sAdOeN,
  output logic [3:0]       sCbeOutN,
  output logic             sCbeOeN,
  output logic             sFrameOutN,
  output logic             sFrameOeN,
  output logic             sIrdyOutN,
  output logic             sIrdyOeN,
  input  wire logic        sFrameInN,
  input  wire logic        sIrdyInN,
  input  wire logic        sTrdyInN,
  input  wire logic        sStopInN,
  input  wire logic        sDevselInN,
  input  wire logic [31:0] memBase,
  input  wire logic [31:0] memLimit,
  input  wire logic [31:0] ioBase,
  input  wire logic [31:0] ioLimit,
  input  wire logic        vgaEnable,
  input  wire logic [7:0]  cacheLineSize,
  input  wire logic [7:0]  latencyTimer,
  input  wire logic        serrEnable,
  input  wire logic        cfgWe,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [31:0] cfgWdata,
  output logic [31:0]      cfgRdata
);
  logic [37:0] pSync1_q, pSync2_q;
  logic [5:0]  sSync1_q, sSync2_q;
  logic [31:0] pAd;
  logic [3:0]  pCbeN;
  logic        pFrameN, pIrdyN, sFrameN, sIrdyN, sTrdyN, sStopN, sDevselN, sGntN;
  tgt_state_e  tState_q;
  mst_state_e  mState_q;
  dly_state_e  dState_q;
  logic [3:0]  tCmd_q, mCmd_q, dCmd_q, dBe_q, cmdStored;
  logic [31:0] tAddr_q, pAddr_q, mAddr_q, dAddr_q, dData_q, dTimer_q;
  logic [31:0] winvCtrl_q, discardCount_q;
  logic        tPosted_q, tDelayed_q, mDelayed_q, flush_q, serrPulse_q;
  logic [7:0]  latCnt_q;
  logic [32:0] retryCnt_q;
  logic [1:0]  mwiField;
  logic        inMem, inIo, isVga, hitPosted, hitDelayed, postRoom, decodePush;
  logic        lineMode, clsPow2, atBoundary, stopNow, dataPush, lastPh;
  logic        sameTxn, dataMatch, dlyComplete, dlyEnqueue;
  logic        devselAct, trdyAct, stopAct;
  logic        fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [FIFO_WIDTH-1:0] fifoInData, head;
  logic [FIFO_AW:0]      fifoLevel;
  logic        headIsAddr, haveData, irdyAct, lastPhase, phaseDone, xfer, abortSeen;
  logic        flushPop, loadHead, dlyDelivered, dlyRetry, dlyFail, retryHit, discardExpire;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every bus pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pSync1_q <= P_SYNC_RESET;
      pSync2_q <= P_SYNC_RESET;
      sSync1_q <= S_SYNC_RESET;
      sSync2_q <= S_SYNC_RESET;
    end else begin
      pSync1_q <= {pIrdyInN, pFrameInN, pCbeInN, pAdIn};
      pSync2_q <= pSync1_q;
      sSync1_q <= {sGntInN, sDevselInN, sStopInN, sTrdyInN, sIrdyInN, sFrameInN};
      sSync2_q <= sSync1_q;
    end
  end
  assign {pIrdyN, pFrameN, pCbeN, pAd} = pSync2_q;
  assign {sGntN, sDevselN, sStopN, sTrdyN, sIrdyN, sFrameN} = sSync2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      winvCtrl_q     <= WINV_CTRL_RESET;
      discardCount_q <= DISCARD_RESET;
    end else if (cfgWe) begin
      if (cfgAddr == REG_WINV_CTRL) winvCtrl_q <= cfgWdata;
      if (cfgAddr == REG_RETRY_DISCARD) discardCount_q <= cfgWdata;
    end
  end
  assign cfgRdata = (cfgAddr == REG_WINV_CTRL) ? winvCtrl_q :
                    (cfgAddr == REG_RETRY_DISCARD) ? discardCount_q : '0;
  assign mwiField = winvCtrl_q[MWI_FIELD_HI:MWI_FIELD_LO];

  ////////////////////////////////////////////////////////////////////////////////
  // Initiator-bus decode and target side
  assign inMem      = tAddr_q >= memBase && tAddr_q <= memLimit;
  assign inIo       = tAddr_q >= ioBase && tAddr_q <= ioLimit;
  assign isVga      = vgaEnable && tAddr_q >= VGA_LOW && tAddr_q <= VGA_HIGH;
  assign hitPosted  = ((tCmd_q == CMD_MEM_WRITE && !isVga) || tCmd_q == CMD_MWI) && inMem;
  assign hitDelayed = (tCmd_q == CMD_MEM_WRITE && isVga) || (tCmd_q == CMD_IO_WRITE && inIo) ||
                      (tCmd_q == CMD_CFG_WRITE && tAddr_q[1:0] == CFG_TYPE1);
  assign postRoom   = fifoLevel <= LEVEL_ROOM;
  assign decodePush = tState_q == T_DECODE && hitPosted && postRoom;
  assign cmdStored  = (tCmd_q == CMD_MWI && mwiField == MWI_AS_WRITE) ? CMD_MEM_WRITE : tCmd_q;

  assign lineMode   = tCmd_q == CMD_MWI && mwiField == MWI_LINE_DISC;
  assign clsPow2    = cacheLineSize != '0 && cacheLineSize <= CLS_MAX &&
                      (cacheLineSize & (cacheLineSize - 8'h01)) == '0;
  assign atBoundary = pAddr_q[11:2] == PAGE_LAST_WORD ||
                      (lineMode && clsPow2 &&
                       ((pAddr_q[9:2] + 8'h01) & (cacheLineSize - 8'h01)) == '0);
  assign stopNow    = tState_q == T_DATA && (atBoundary || fifoLevel >= LEVEL_NEAR || !fifoInReady);
  assign dataPush   = tState_q == T_DATA && !pIrdyN;
  assign lastPh     = pFrameN || stopNow;

  assign sameTxn     = dState_q != D_EMPTY && dCmd_q == tCmd_q && dAddr_q == tAddr_q;
  always_comb begin
    dataMatch = sameTxn && dBe_q == pCbeN;
    for (int b = 0; b < 4; b++) begin
      if (!pCbeN[b] && dData_q[8*b +: 8] != pAd[8*b +: 8]) dataMatch = 1'b0;
    end
  end
  assign dlyComplete = tState_q == T_DLY && !pIrdyN && tDelayed_q && dState_q == D_DONE &&
                       dataMatch;
  assign dlyEnqueue  = tState_q == T_DLY && !pIrdyN && tDelayed_q && dState_q == D_EMPTY;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tState_q   <= T_IDLE;
      tCmd_q     <= '0;
      tAddr_q    <= '0;
      pAddr_q    <= '0;
      tPosted_q  <= 1'b0;
      tDelayed_q <= 1'b0;
    end else begin
      case (tState_q)
        T_IDLE: begin
          tCmd_q  <= pCbeN;
          tAddr_q <= pAd;
          if (!pFrameN) tState_q <= T_DECODE;
        end
        T_DECODE: begin
          pAddr_q    <= tAddr_q;
          tPosted_q  <= hitPosted && postRoom;
          tDelayed_q <= hitDelayed;
          tState_q   <= (hitPosted || hitDelayed) ? T_CLAIM : T_WAIT;
        end
        T_CLAIM: tState_q <= tPosted_q ? T_DATA : T_DLY;
        T_DATA: begin
          if (!pIrdyN) begin
            pAddr_q <= pAddr_q + ADDR_STEP;
            if (lastPh) tState_q <= T_WAIT;
          end
        end
        T_DLY: if (!pIrdyN) tState_q <= T_WAIT;
        T_WAIT: if (pFrameN && pIrdyN) tState_q <= T_IDLE;
        default: tState_q <= T_IDLE;
      endcase
    end
  end

  assign devselAct   = tState_q == T_CLAIM || tState_q == T_DATA || tState_q == T_DLY;
  assign trdyAct     = tState_q == T_DATA || dlyComplete;
  assign stopAct     = stopNow || (tState_q == T_DLY && !pIrdyN &&
                       !(dlyComplete && pFrameN));
  assign pDevselOutN = !devselAct;
  assign pTrdyOutN   = !trdyAct;
  assign pStopOutN   = !stopAct;
  assign pDevselOeN  = !devselAct;
  assign pTrdyOeN    = !devselAct;
  assign pStopOeN    = !devselAct;

  ////////////////////////////////////////////////////////////////////////////////
  // Posted write queue
  assign fifoInValid = decodePush || dataPush;
  assign fifoInData  = decodePush ? {1'b1, 1'b0, cmdStored, tAddr_q} : {1'b0, lastPh, pCbeN, pAd};

  post_write_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (head),
    .level    (fifoLevel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Target-bus master
  assign headIsAddr   = head[FW_IS_ADDR];
  assign haveData     = mDelayed_q || (fifoOutValid && !headIsAddr);
  assign irdyAct      = mState_q == M_DATA && haveData;
  assign lastPhase    = mDelayed_q || head[FW_EOT] || fifoLevel == LEVEL_ONE ||
                        (latCnt_q == '0 && sGntN);
  assign phaseDone    = irdyAct && (!sTrdyN || !sStopN);
  assign xfer         = irdyAct && !sTrdyN;
  assign abortSeen    = irdyAct && !sStopN && sDevselN;
  assign flushPop     = mState_q == M_IDLE && flush_q && fifoOutValid && !headIsAddr;
  assign loadHead     = mState_q == M_REQ && !sGntN && sFrameN && sIrdyN && !mDelayed_q &&
                        fifoOutValid && headIsAddr;
  assign fifoOutReady = flushPop || loadHead || (xfer && !mDelayed_q);
  assign dlyDelivered = xfer && mDelayed_q;
  assign dlyRetry     = irdyAct && mDelayed_q && !sStopN && sTrdyN && !sDevselN;
  assign retryHit     = dlyRetry && retryCnt_q + 33'h1 >= RETRY_LIMIT;
  assign dlyFail      = (abortSeen && mDelayed_q) || retryHit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mState_q   <= M_IDLE;
      mDelayed_q <= 1'b0;
      mAddr_q    <= '0;
      mCmd_q     <= '0;
      latCnt_q   <= '0;
      flush_q    <= 1'b0;
    end else begin
      case (mState_q)
        M_IDLE: begin
          if (flush_q && fifoOutValid && headIsAddr) flush_q <= 1'b0;
          if (fifoOutValid && !flushPop && !(flush_q && !headIsAddr)) begin
            mDelayed_q <= 1'b0;
            mState_q   <= M_REQ;
          end else if (!fifoOutValid && dState_q == D_PEND) begin
            mDelayed_q <= 1'b1;
            mState_q   <= M_REQ;
          end
        end
        M_REQ: begin
          if (!sGntN && sFrameN && sIrdyN) begin
            mState_q <= M_ADDR;
            if (mDelayed_q) begin
              mAddr_q <= dAddr_q;
              mCmd_q  <= dCmd_q;
            end else if (loadHead) begin
              mAddr_q <= head[31:0];
              mCmd_q  <= head[35:32];
            end
          end
        end
        M_ADDR: begin
          latCnt_q <= latencyTimer;
          mState_q <= M_DATA;
        end
        M_DATA: begin
          if (latCnt_q != '0) latCnt_q <= latCnt_q - 8'h01;
          if (xfer) mAddr_q <= mAddr_q + ADDR_STEP;
          if (abortSeen && !mDelayed_q) flush_q <= 1'b1;
          if (phaseDone && (lastPhase || !sStopN)) mState_q <= M_TURN;
        end
        M_TURN: mState_q <= M_IDLE;
        default: mState_q <= M_IDLE;
      endcase
    end
  end

  assign sReqOutN   = mState_q != M_REQ;
  assign sAdOut     = (mState_q == M_ADDR) ? mAddr_q : (mDelayed_q ? dData_q : head[31:0]);
  assign sCbeOutN   = (mState_q == M_ADDR) ? mCmd_q : (mDelayed_q ? dBe_q : head[35:32]);
  assign sAdOeN     = !(mState_q == M_ADDR || mState_q == M_DATA);
  assign sCbeOeN    = sAdOeN;
  assign sFrameOutN = !(mState_q == M_ADDR || (mState_q == M_DATA && !lastPhase));
  assign sFrameOeN  = !(mState_q == M_ADDR || mState_q == M_DATA || mState_q == M_TURN);
  assign sIrdyOutN  = !irdyAct;
  assign sIrdyOeN   = !(mState_q == M_DATA || mState_q == M_TURN);

  ////////////////////////////////////////////////////////////////////////////////
  // Delayed write entry, retry count and discard timer
  assign discardExpire = dState_q == D_DONE && dTimer_q == '0 && !dlyComplete;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dState_q   <= D_EMPTY;
      dCmd_q     <= '0;
      dAddr_q    <= '0;
      dData_q    <= '0;
      dBe_q      <= '0;
      dTimer_q   <= '0;
      retryCnt_q <= '0;
    end else begin
      case (dState_q)
        D_EMPTY: begin
          if (dlyEnqueue) begin
            dCmd_q     <= tCmd_q;
            dAddr_q    <= tAddr_q;
            dData_q    <= pAd;
            dBe_q      <= pCbeN;
            retryCnt_q <= '0;
            dState_q   <= D_PEND;
          end
        end
        D_PEND: begin
          if (dlyRetry) retryCnt_q <= retryCnt_q + 33'h1;
          if (dlyDelivered) begin
            dTimer_q <= discardCount_q;
            dState_q <= D_DONE;
          end else if (dlyFail) begin
            dState_q <= D_EMPTY;
          end
        end
        D_DONE: begin
          if (dTimer_q != '0) dTimer_q <= dTimer_q - 32'h1;
          if (dlyComplete || discardExpire) dState_q <= D_EMPTY;
        end
        default: dState_q <= D_EMPTY;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) serrPulse_q <= 1'b0;
    else serrPulse_q <= serrEnable && (retryHit || discardExpire);
  end
  assign primary_system_error_out_n = 1'b0;
  assign pSerrOeN = !serrPulse_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_positive_claim;
    $rose(devselAct) |-> $past(tState_q) == T_DECODE && $past(hitPosted || hitDelayed);
  endproperty
  a_positive_claim: assert property (p_positive_claim) else $error("claim without decode hit");

  sequence s_claim_posted;
    tState_q == T_CLAIM && tPosted_q && devselAct && !trdyAct;
  endsequence
  sequence s_trdy_follows;
    ##1 (tState_q == T_DATA && trdyAct && devselAct);
  endsequence
  property p_posted_trdy;
    s_claim_posted |-> s_trdy_follows;
  endproperty
  a_posted_trdy: assert property (p_posted_trdy) else $error("posted TRDY not one after DEVSEL");

  property p_push_on_handshake;
    fifoInValid && !fifoInData[FW_IS_ADDR] |-> trdyAct && !pIrdyN;
  endproperty
  a_push_on_handshake: assert property (p_push_on_handshake) else $error("data queued without handshake");

  property p_full_disconnect;
    tState_q == T_DATA && fifoLevel >= LEVEL_NEAR |-> stopAct && trdyAct;
  endproperty
  a_full_disconnect: assert property (p_full_disconnect) else $error("no disconnect when buffer full");

  property p_request_head;
    mState_q == M_IDLE && fifoOutValid && !flush_q |=> !sReqOutN;
  endproperty
  a_request_head: assert property (p_request_head) else $error("no request with posted data");

  sequence s_addr_phase;
    mState_q == M_ADDR && !sFrameOutN && !sAdOeN;
  endsequence
  property p_addr_then_data;
    s_addr_phase |=> mState_q == M_DATA && $past(sAdOut) == mAddr_q;
  endproperty
  a_addr_then_data: assert property (p_addr_then_data) else $error("address not followed by data");

  property p_single_dword;
    mState_q == M_DATA && mDelayed_q |-> sFrameOutN;
  endproperty
  a_single_dword: assert property (p_single_dword) else $error("delayed write not single word");

  property p_mwi_convert;
    decodePush && tCmd_q == CMD_MWI && mwiField == MWI_AS_WRITE |->
      fifoInData[35:32] == CMD_MEM_WRITE;
  endproperty
  a_mwi_convert: assert property (p_mwi_convert) else $error("invalidate not converted");

  property p_retry_pending;
    tState_q == T_DLY && !pIrdyN && dState_q == D_PEND |->
      (stopAct && !trdyAct) ##1 (dState_q != D_EMPTY || $past(dlyFail));
  endproperty
  a_retry_pending: assert property (p_retry_pending) else $error("repeat not retried");

  property p_discard;
    discardExpire |=> dState_q == D_EMPTY && pSerrOeN == !$past(serrEnable);
  endproperty
  a_discard: assert property (p_discard) else $error("completion not discarded");

endmodule

// File: tb/pci_target_model.sv
// Target-bus agent: grants on request, answers without waits, logs writes.
// Assumes control lines are pulled up while the bridge releases them.
module pci_target_model (
  input  wire logic        clk_sys,
  input  wire logic        sReqOutN,
  input  wire logic [31:0] sAdOut,
  input  wire logic [3:0]  sCbeOutN,
  input  wire logic        sFrameOutN,
  input  wire logic        sFrameOeN,
  input  wire logic        sIrdyOutN,
  input  wire logic        sIrdyOeN,
  input  wire logic        gntHold,
  output logic             sGntInN,
  output logic             sFrameInN,
  output logic             sIrdyInN,
  output logic             sTrdyInN,
  output logic             sStopInN,
  output logic             sDevselInN,
  output logic [31:0]      seenAddr,
  output logic [3:0]       seenCmd,
  output logic [31:0]      seenData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act = 1'b0;
  assign sFrameInN  = sFrameOeN | sFrameOutN;
  assign sIrdyInN   = sIrdyOeN | sIrdyOutN;
  assign sStopInN   = 1'b1;
  assign sDevselInN = ~act;
  assign sTrdyInN   = ~act;
  always @(posedge clk_sys) begin
    sGntInN <= sReqOutN | gntHold;
    if (!act && !sFrameInN) begin
      act      <= 1'b1;
      seenAddr <= sAdOut;
      seenCmd  <= sCbeOutN;
    end
    if (act && !sIrdyInN) begin
      seenData <= sAdOut;
    end
    if (act && sFrameInN && sIrdyInN) begin
      act <= 1'b0;
    end
  end
endmodule

// File: tb/pci_bridge_write_forwarding_tb.sv
// Bench: register port, posted, invalidate and delayed writes.
// Assumes pci_target_model stands on the target bus.
module pci_bridge_write_forwarding_tb
  import pci_bridge_write_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst = 1'b1, cfgWe = 1'b0, serrSeen = 1'b0, gntHold = 1'b0;
  logic        pFrameInN = 1'b1, pIrdyInN = 1'b1, vgaEnable = 1'b1, serrEnable = 1'b1;
  logic [31:0] pAdIn = 32'h0, cfgWdata = 32'h0, memBase = 32'h1000_0000;
  logic [31:0] memLimit = 32'h1fff_ffff, ioBase = 32'h1000, ioLimit = 32'h1fff;
  logic [31:0] cfgRdata, sAdOut, seenAddr, seenData;
  logic [7:0]  cfgAddr = 8'h0, cacheLineSize = 8'h08, latencyTimer = 8'h10;
  logic [3:0]  pCbeInN = 4'hf, sCbeOutN, seenCmd;
  logic [1:0]  r;
  logic        pDevselOutN, pDevselOeN, pTrdyOutN, pTrdyOeN, pStopOutN, pStopOeN;
  logic        pSerrOeN, primary_system_error_out_n, sReqOutN, sGntInN, sAdOeN;
  logic        sCbeOeN, sFrameOutN, sFrameOeN, sIrdyOutN, sIrdyOeN, sFrameInN;
  logic        sIrdyInN, sTrdyInN, sStopInN, sDevselInN;
  int          fail_count = 0, total_checks = 0, cyc = 0;

  pci_bridge_write_forwarding #(.RETRY_LIMIT(33'h4)) dut_u (.*);
  pci_target_model far_u (.*);

  initial forever #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!rst && pSerrOeN === 1'b0) serrSeen <= 1'b1;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic regAcc(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgWdata = d;
    cfgWe = wr;
    #1 if (!wr) chk(cfgRdata, d);
  endtask
  task automatic busWr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c);
    int n = 0;
    @(negedge clk_sys);
    cfgWe = 1'b0;
    pAdIn = a;
    pCbeInN = c;
    pFrameInN = 1'b0;
    while (pDevselOeN !== 1'b0 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    pAdIn = d;
    pCbeInN = 4'h0;
    pIrdyInN = 1'b0;
    pFrameInN = 1'b1;
    while ({pStopOutN, pTrdyOutN} === 2'b11 && n < 24) begin
      @(negedge clk_sys);
      n++;
    end
    r = {pStopOutN, pTrdyOutN};
    @(negedge clk_sys);
    pIrdyInN = 1'b1;
    pCbeInN = 4'hf;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic fwd(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c);
    int n = 0;
    while (seenData !== d && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk(seenAddr, a);
    chk({seenCmd, seenData}, {c, d});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    regAcc(REG_WINV_CTRL, 1'b0, WINV_CTRL_RESET);
    regAcc(REG_RETRY_DISCARD, 1'b0, DISCARD_RESET);
    regAcc(8'h50, 1'b1, 32'h1234_5678);
    regAcc(8'h50, 1'b0, 32'h0);
    regAcc(REG_RETRY_DISCARD, 1'b1, 32'h40);
    regAcc(REG_RETRY_DISCARD, 1'b0, 32'h40);
    busWr(32'h1000_0010, 32'hcafe_0001, CMD_MEM_WRITE);
    chk(r, 2'b10);
    fwd(32'h1000_0010, 32'hcafe_0001, CMD_MEM_WRITE);
    busWr(32'h1000_0040, 32'hbeef_0002, CMD_MWI);
    chk(r, 2'b10);
    fwd(32'h1000_0040, 32'hbeef_0002, CMD_MEM_WRITE);
    regAcc(REG_WINV_CTRL, 1'b1, 32'h180);
    regAcc(REG_WINV_CTRL, 1'b0, 32'h180);
    busWr(32'h1000_005c, 32'hbeef_0005, CMD_MWI);
    chk(r, 2'b00);
    fwd(32'h1000_005c, 32'hbeef_0005, CMD_MWI);
    busWr(32'h3000_0000, 32'h1, CMD_MEM_WRITE);
    chk(r, 2'b11);
    gntHold = 1'b1;
    busWr(32'h1004, 32'h0bad_f00d, CMD_IO_WRITE);
    chk(r, 2'b01);
    busWr(32'h1004, 32'h0bad_f00d, CMD_IO_WRITE);
    chk(r, 2'b01);
    gntHold = 1'b0;
    fwd(32'h1004, 32'h0bad_f00d, CMD_IO_WRITE);
    busWr(32'h1004, 32'h0bad_f00d, CMD_IO_WRITE);
    chk(r, 2'b10);
    busWr(VGA_LOW, 32'h5a5a_0003, CMD_MEM_WRITE);
    chk(r, 2'b01);
    fwd(VGA_LOW, 32'h5a5a_0003, CMD_MEM_WRITE);
    repeat (100) @(negedge clk_sys);
    busWr(VGA_LOW, 32'h5a5a_0003, CMD_MEM_WRITE);
    chk(r, 2'b01);
    chk(serrSeen, 1'b1);
    test_done();
  end
endmodule
